// ==== rtl/camds_pkg.sv ====
package camds_pkg;

  // data widths and storage sizes
  localparam int DW = 16;
  localparam int NREG = 16;
  localparam int NMEM = 16;
  localparam int IDX_W = 4;

  // register map, byte addresses on the bus
  localparam logic [31:0] OFF_CMD = 32'h0000_0000;
  localparam logic [31:0] OFF_FLAGS = 32'h0000_0004;
  localparam logic [31:0] OFF_STAT = 32'h0000_0008;
  localparam logic [31:0] BASE_WREG = 32'h0000_0040;
  localparam logic [31:0] BASE_DMEM = 32'h0000_0080;
  localparam int WIN_SHIFT = 6;

  // command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_BYTE = 4;
  localparam int CMD_AMEM = 5;
  localparam int CMD_DMEM = 6;
  localparam int CMD_ASR = 7;
  localparam int CMD_A_LSB = 8;
  localparam int CMD_B_LSB = 12;
  localparam int CMD_D_LSB = 16;
  localparam int CMD_LIT_LSB = 20;
  localparam int LIT_W = 5;
  localparam int CMD_GO = 31;
  localparam logic [31:0] CMD_RST = 32'h0000_0000;
  localparam logic [31:0] CMD_GO_MASK = 32'h8000_0000;

  // status flags register fields
  localparam int FL_C = 0;
  localparam int FL_Z = 1;
  localparam int FL_OV = 2;
  localparam int FL_N = 3;
  localparam int FL_DC = 4;
  localparam int FL_W = 5;
  localparam logic [FL_W-1:0] FLAGS_RST = 5'h00;
  localparam int STAT_BUSY = 0;

  // divide results land in fixed working registers
  localparam logic [IDX_W-1:0] QUOT_IDX = 4'h0;
  localparam logic [IDX_W-1:0] REM_IDX = 4'h1;

  // one iteration per divisor bit
  localparam int DIV_BITS = 16;
  localparam int DIV_CNT_W = 5;
  localparam logic [DIV_CNT_W-1:0] DIV_LAST = DIV_CNT_W'(DIV_BITS - 1);

  typedef enum logic [CMD_OP_W-1:0] {
    OP_ADD, OP_SUB, OP_AND, OP_IOR, OP_XOR, OP_SHIFT,
    OP_MUL_SS, OP_MUL_UU, OP_MUL_SL, OP_MUL_UL, OP_MUL_US, OP_MUL_BB,
    OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16
  } camds_op_e;

endpackage : camds_pkg

// ==== rtl/camds_div_if.sv ====
`timescale 1ns/1ps
interface camds_div_if;
  logic start;
  logic is_signed;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic done;
  logic [15:0] quot;
  logic [15:0] rem;
  modport eng (input start, is_signed, dividend, divisor, output done, quot, rem);
  modport user (output start, is_signed, dividend, divisor, input done, quot, rem);
endinterface : camds_div_if

// ==== rtl/camds_div.sv ====
`timescale 1ns/1ps
module camds_div
  import camds_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  camds_div_if.eng dv
);

  typedef enum logic {DS_IDLE, DS_RUN} camds_dst_e;

  camds_dst_e state;
  logic [15:0] rem_acc;
  logic [15:0] quo_acc;
  logic [15:0] dsr;
  logic [DIV_CNT_W-1:0] cnt;
  logic neg_q;
  logic neg_r;
  logic [31:0] mag;
  logic [16:0] trial;
  logic [15:0] next_rem;
  logic [15:0] next_quo;

  // restoring divide on magnitudes, signs applied at the end
  always_comb begin
    mag = (dv.is_signed && dv.dividend[31]) ? -dv.dividend : dv.dividend;
    trial = {rem_acc, quo_acc[15]};
    if (trial >= {1'b0, dsr}) begin
      next_rem = 16'(trial - {1'b0, dsr});
      next_quo = {quo_acc[14:0], 1'b1};
    end else begin
      next_rem = trial[15:0];
      next_quo = {quo_acc[14:0], 1'b0};
    end
  end

  // quotient must fit 16 bits: the upper dividend half stays below the divisor
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= DS_IDLE;
      rem_acc <= 16'h0000;
      quo_acc <= 16'h0000;
      dsr <= 16'h0000;
      cnt <= '0;
      neg_q <= 1'b0;
      neg_r <= 1'b0;
    end else begin
      unique case (state)
        DS_IDLE: begin
          if (dv.start) begin
            rem_acc <= mag[31:16];
            quo_acc <= mag[15:0];
            dsr <= (dv.is_signed && dv.divisor[15]) ? -dv.divisor : dv.divisor; // [RQ2]
            neg_q <= dv.is_signed & (dv.dividend[31] ^ dv.divisor[15]);
            neg_r <= dv.is_signed & dv.dividend[31];
            cnt <= '0;
            state <= DS_RUN;
          end
        end
        DS_RUN: begin
          rem_acc <= next_rem;
          quo_acc <= next_quo;
          cnt <= cnt + 1'b1; // [RQ12]
          if (cnt == DIV_LAST) begin
            state <= DS_IDLE;
          end
        end
      endcase
    end
  end

  // results appear only after the last iteration
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dv.done <= 1'b0;
      dv.quot <= 16'h0000;
      dv.rem <= 16'h0000;
    end else begin
      dv.done <= (state == DS_RUN) && (cnt == DIV_LAST); // [RQ16]
      if ((state == DS_RUN) && (cnt == DIV_LAST)) begin
        dv.quot <= neg_q ? -next_quo : next_quo; // [RQ9]
        dv.rem <= neg_r ? -next_rem : next_rem;
      end
    end
  end

endmodule : camds_div

// ==== rtl/camds_top.sv ====
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Operation
// RQ1 - 16-bit add, subtract, shift, logic operations
// RQ2 - arithmetic is two's complement unless unsigned
// RQ3 - update carry, zero, negative, overflow, digit carry
// RQ4 - subtraction: carry is borrow, digit carry digit borrow (the code sets both as "no borrow": 1 when nothing is borrowed)
// RQ5 - byte or word width per command
// RQ6 - operands and results: registers or data memory
// RQ7 - 17x17 multiplier gives signed, unsigned, mixed products
// RQ8 - five multiplier signedness and width modes (the code has six: SS, UU, SL, UL, US, BB)
// RQ9 - signed/unsigned 32/16 and 16/16 division
// RQ10 - quotient and remainder to fixed result registers
// RQ11 - divisor any register, dividend aligned register pair
// RQ12 - one cycle per divisor bit, equal cycle counts
// RQ13 - single-cycle shift up to sixteen positions
// RQ14 - shift operand from register or memory
// RQ15 - signed amount: positive right, negative left
// RQ16 - stall issuer during divide, write results at end
module camds_top
  import camds_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  output logic ALU_BUSY
);

  function automatic logic in_win(input logic [31:0] addr, input logic [31:0] base);
    return addr[31:WIN_SHIFT] == base[31:WIN_SHIFT];
  endfunction : in_win

  // a byte operand sits in the top half so carry and sign come out of bit 15
  function automatic logic [15:0] align_op(input logic [15:0] v, input logic bmode);
    return bmode ? {v[7:0], 8'h00} : v;
  endfunction : align_op

  logic [15:0] wreg [NREG];
  logic [15:0] dmem [NMEM];
  logic [31:0] cmd;
  logic go;
  logic [FL_W-1:0] flags;
  logic ph_valid;
  logic ph_write;
  logic [31:0] ph_addr;
  logic accept;
  logic wr_now;
  logic launch;
  logic [31:0] rd_data;

  camds_op_e op;
  logic bmode;
  logic a_mem;
  logic d_mem;
  logic asr;
  logic [IDX_W-1:0] a_idx;
  logic [IDX_W-1:0] b_idx;
  logic [IDX_W-1:0] d_idx;
  logic [IDX_W-1:0] d_lo;
  logic [IDX_W-1:0] d_hi;
  logic [IDX_W-1:0] pair_lo;
  logic [IDX_W-1:0] pair_hi;
  logic [LIT_W-1:0] lit;
  logic is_div;
  logic is_mul;
  logic is_arith;
  logic [15:0] a_val;
  logic [15:0] b_val;
  logic [15:0] d_old;

  logic [15:0] a_al;
  logic [15:0] b_al;
  logic [15:0] bx;
  logic [16:0] sum;
  logic [15:0] cin;
  logic [15:0] res_al;
  logic [15:0] wb;
  logic c_f;
  logic dc_f;
  logic ov_f;

  logic [5:0] amt;
  logic [5:0] mag;
  logic sg;
  logic [31:0] ext;
  logic [31:0] sh_r;
  logic [31:0] sh_l;
  logic [15:0] sh;

  logic [16:0] ea;
  logic [16:0] eb;
  logic signed [33:0] prod;
  logic [31:0] p32;

  camds_div_if dv ();

  camds_div u_div (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .dv(dv.eng)
  );

  // command decode
  assign op = camds_op_e'(cmd[CMD_OP_LSB +: CMD_OP_W]);
  assign bmode = cmd[CMD_BYTE];
  assign a_mem = cmd[CMD_AMEM];
  assign d_mem = cmd[CMD_DMEM];
  assign asr = cmd[CMD_ASR];
  assign a_idx = cmd[CMD_A_LSB +: IDX_W];
  assign b_idx = cmd[CMD_B_LSB +: IDX_W];
  assign d_idx = cmd[CMD_D_LSB +: IDX_W];
  assign lit = cmd[CMD_LIT_LSB +: LIT_W];
  assign d_lo = {d_idx[IDX_W-1:1], 1'b0};
  assign d_hi = {d_idx[IDX_W-1:1], 1'b1};
  assign pair_lo = {a_idx[IDX_W-1:1], 1'b0};
  assign pair_hi = {a_idx[IDX_W-1:1], 1'b1};
  assign is_div = op inside {OP_DIV_S32, OP_DIV_U32, OP_DIV_S16, OP_DIV_U16};
  assign is_mul = op inside {OP_MUL_SS, OP_MUL_UU, OP_MUL_SL, OP_MUL_UL, OP_MUL_US, OP_MUL_BB};
  assign is_arith = (op == OP_ADD) || (op == OP_SUB);

  assign a_val = a_mem ? dmem[a_idx] : wreg[a_idx]; // [RQ6] [RQ14]
  assign b_val = wreg[b_idx];
  assign d_old = d_mem ? dmem[d_idx] : wreg[d_idx];

  // add, subtract and logic on aligned operands
  always_comb begin
    a_al = align_op(a_val, bmode); // [RQ5]
    b_al = align_op(b_val, bmode);
    bx = (op == OP_SUB) ? ~b_al : b_al;
    sum = {1'b0, a_al} + {1'b0, bx} + {16'h0000, op == OP_SUB}; // [RQ1] [RQ2]
    cin = sum[15:0] ^ a_al ^ bx;
    // carry out is "no borrow" on subtract, the same for the digit carry
    c_f = sum[16]; // [RQ4]
    dc_f = bmode ? cin[12] : cin[8]; // [RQ4]
    ov_f = (a_al[15] == bx[15]) && (sum[15] != a_al[15]);
    unique case (op)
      OP_AND: res_al = a_al & b_al;
      OP_IOR: res_al = a_al | b_al;
      OP_XOR: res_al = a_al ^ b_al;
      OP_SHIFT: res_al = align_op(sh, bmode);
      default: res_al = sum[15:0];
    endcase
    // byte results leave the upper byte of the destination untouched
    wb = bmode ? {d_old[15:8], res_al[15:8]} : res_al;
  end

  // barrel shifter, sign of the amount picks the direction
  always_comb begin
    amt = b_val[5:0];
    mag = amt[5] ? -amt : amt; // [RQ15]
    sg = asr & (bmode ? a_val[7] : a_val[15]);
    ext = bmode ? {{24{sg}}, a_val[7:0]} : {{16{sg}}, a_val};
    sh_r = ext >> mag; // [RQ13]
    sh_l = {16'h0000, a_val} << mag;
    if (amt == 6'h00) begin
      sh = a_val; // [RQ15]
    end else if (amt[5]) begin
      sh = sh_l[15:0];
    end else begin
      sh = sh_r[15:0];
    end
  end

  // 17x17 signed multiply; the extra bit is a sign or a zero per mode
  always_comb begin
    unique case (op)
      OP_MUL_SS: begin
        ea = {a_val[15], a_val};
        eb = {b_val[15], b_val};
      end
      OP_MUL_SL: begin
        ea = {a_val[15], a_val};
        eb = {12'h000, lit};
      end
      OP_MUL_UL: begin
        ea = {1'b0, a_val};
        eb = {12'h000, lit};
      end
      OP_MUL_US: begin
        ea = {1'b0, a_val};
        eb = {b_val[15], b_val};
      end
      OP_MUL_BB: begin
        ea = {9'h000, a_val[7:0]};
        eb = {9'h000, b_val[7:0]};
      end
      default: begin
        ea = {1'b0, a_val};
        eb = {1'b0, b_val};
      end
    endcase
    prod = $signed(ea) * $signed(eb); // [RQ7] [RQ8]
    p32 = prod[31:0];
  end

  // divider operands: divisor from any register, dividend from an aligned pair for 32/16 or from register A for 16/16
  assign dv.start = go & is_div;
  assign dv.is_signed = (op == OP_DIV_S32) || (op == OP_DIV_S16);
  assign dv.divisor = wreg[b_idx]; // [RQ11]
  always_comb begin
    unique case (op)
      OP_DIV_S32, OP_DIV_U32: dv.dividend = {wreg[pair_hi], wreg[pair_lo]}; // [RQ11] [RQ9]
      OP_DIV_S16: dv.dividend = {{16{wreg[a_idx][15]}}, wreg[a_idx]};
      default: dv.dividend = {16'h0000, wreg[a_idx]};
    endcase
  end

  // bus slave
  assign accept = HSEL & HTRANS[1] & HREADY;
  assign wr_now = ph_valid & ph_write & HREADYOUT;
  assign launch = wr_now & (ph_addr == OFF_CMD) & HWDATA[CMD_GO];

  always_comb begin
    if (ph_addr == OFF_CMD) begin
      rd_data = cmd;
    end else if (ph_addr == OFF_FLAGS) begin
      rd_data = {27'h0000000, flags};
    end else if (ph_addr == OFF_STAT) begin
      rd_data = {31'h00000000, ALU_BUSY};
    end else if (in_win(ph_addr, BASE_WREG)) begin
      rd_data = {16'h0000, wreg[ph_addr[5:2]]};
    end else if (in_win(ph_addr, BASE_DMEM)) begin
      rd_data = {16'h0000, dmem[ph_addr[5:2]]};
    end else begin
      rd_data = 32'h00000000;
    end
  end

  // reads always wait one cycle; anything waits while the engine works
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRDATA <= 32'h00000000;
      HRESP <= 1'b0;
    end else if (HREADYOUT) begin
      ph_valid <= accept;
      if (accept) begin
        ph_write <= HWRITE;
        ph_addr <= HADDR;
        HREADYOUT <= HWRITE & ~(ALU_BUSY | launch); // [RQ16]
      end
    end else if (!ALU_BUSY) begin // [RQ16]
      HRDATA <= rd_data;
      HREADYOUT <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      cmd <= CMD_RST;
    end else if (wr_now && (ph_addr == OFF_CMD)) begin
      cmd <= HWDATA & ~CMD_GO_MASK;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      go <= 1'b0;
    end else begin
      go <= launch;
    end
  end

  // busy covers the execute cycle and the whole divide
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ALU_BUSY <= 1'b0;
    end else if (launch) begin
      ALU_BUSY <= 1'b1;
    end else if ((go && !is_div) || dv.done) begin
      ALU_BUSY <= 1'b0; // [RQ16]
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags <= FLAGS_RST;
    end else if (wr_now && (ph_addr == OFF_FLAGS)) begin
      flags <= HWDATA[FL_W-1:0];
    end else if (go && is_arith) begin
      flags[FL_C] <= c_f; // [RQ3]
      flags[FL_DC] <= dc_f;
      flags[FL_OV] <= ov_f;
      flags[FL_Z] <= (res_al == 16'h0000);
      flags[FL_N] <= res_al[15];
    end else if (go && !is_mul && !is_div) begin
      flags[FL_Z] <= (res_al == 16'h0000); // [RQ3]
      flags[FL_N] <= res_al[15];
    end
  end

  // register array and data memory; the engine never writes while the bus does
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      for (int i = 0; i < NREG; i++) begin
        wreg[i] <= 16'h0000;
      end
      for (int i = 0; i < NMEM; i++) begin
        dmem[i] <= 16'h0000;
      end
    end else begin
      if (wr_now && in_win(ph_addr, BASE_WREG)) begin
        wreg[ph_addr[5:2]] <= HWDATA[15:0];
      end
      if (wr_now && in_win(ph_addr, BASE_DMEM)) begin
        dmem[ph_addr[5:2]] <= HWDATA[15:0];
      end
      if (go && is_mul) begin
        if (d_mem) begin
          dmem[d_lo] <= p32[15:0];
          dmem[d_hi] <= p32[31:16];
        end else begin
          wreg[d_lo] <= p32[15:0];
          wreg[d_hi] <= p32[31:16];
        end
      end else if (go && !is_div) begin
        if (d_mem) begin
          dmem[d_idx] <= wb; // [RQ6]
        end else begin
          wreg[d_idx] <= wb;
        end
      end
      if (dv.done) begin
        wreg[QUOT_IDX] <= dv.quot; // [RQ10]
        wreg[REM_IDX] <= dv.rem;
      end
    end
  end

endmodule : camds_top

// ==== testbench/camds_checker.sv ====
`timescale 1ns/1ps
module camds_checker
  import camds_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic ALU_BUSY
);
  logic dph;
  logic cmd_ph;
  wire logic taken = HSEL && HTRANS[1] && HREADY;
  wire logic launch = cmd_ph && HREADY && HWDATA[CMD_GO];

  // data-phase trackers only move when the bus is ready, so a stalled phase keeps its meaning
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dph <= 1'b0;
      cmd_ph <= 1'b0;
    end else if (HREADY) begin
      dph <= taken;
      cmd_ph <= taken && HWRITE && HADDR == OFF_CMD;
    end
  end

  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence launch_div_s;
    launch && HWDATA[3:2] == 2'h3;
  endsequence
  sequence launch_one_s;
    launch && HWDATA[3:2] != 2'h3;
  endsequence
  sequence busy18_s;
    ALU_BUSY[*6] ##1 ALU_BUSY[*6] ##1 ALU_BUSY[*6];
  endsequence

  okay_resp_a: assert property (HRESP == 1'b0) else $error("bus response not okay");
  div_cycles_a: assert property (launch_div_s |=> busy18_s ##1 !ALU_BUSY)
    else $error("divide busy span wrong");
  one_cycle_a: assert property (launch_one_s |=> ALU_BUSY ##1 !ALU_BUSY)
    else $error("single cycle op busy span wrong");
  busy_stall_a: assert property (dph && ALU_BUSY |-> !HREADYOUT)
    else $error("access completed while busy");
  stall_bound_a: assert property (ALU_BUSY |-> ##[1:19] !ALU_BUSY)
    else $error("busy held too long");
  read_wait_a: assert property (taken && !HWRITE && !ALU_BUSY && !launch |=> !HREADYOUT ##1 HREADYOUT)
    else $error("idle read wait state wrong");
  write_fast_a: assert property (taken && HWRITE && !ALU_BUSY && !launch |=> HREADYOUT)
    else $error("idle write stalled");
  rdata_hold_a: assert property (!HREADYOUT ##1 !HREADYOUT |-> $stable(HRDATA))
    else $error("read data moved during wait");
endmodule : camds_checker

bind camds_top camds_checker camds_checker_inst (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .ALU_BUSY(ALU_BUSY)
);

// ==== testbench/camds_issuer.sv ====
`timescale 1ns/1ps
module camds_issuer (
  input wire logic clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end

  // entered just after a rising edge; waits as long as the slave stalls, the bench watchdog bounds it
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    // a read data phase carries no data, so the lines toggle rather than hold a stale word
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : xfer
endmodule : camds_issuer

// ==== testbench/camds_test.sv ====
`timescale 1ns/1ps
module camds_test
  import camds_pkg::*;
;
  logic core_clk;
  logic rst_n;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic alu_busy;
  int n_mismatch = 0;
  int comparisons = 0;

  camds_top camds_top_inst (.CORE_CLK(core_clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .ALU_BUSY(alu_busy));
  camds_issuer camds_issuer_inst (.clk(core_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] unused;
    camds_issuer_inst.xfer(1'b1, a, d, unused);
  endtask : wr

  task automatic rd_chk(input string what, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] v;
    camds_issuer_inst.xfer(1'b0, a, 32'h0000_0000, v);
    check(what, v, exp);
  endtask : rd_chk

  // o[7:0] = mode bits and op, o[12:8] = literal; A is reg/mem 2 (pair 2/3), B reg 7, dest 4 (pair 4/5)
  task automatic run(input logic [15:0] o, input logic [15:0] al, input logic [15:0] ah, input logic [15:0] b,
    input logic [4:0] pre, input logic [1:0] loc, input logic [15:0] e0, input logic [15:0] e1, input logic [4:0] f);
    logic [31:0] c;
    logic [31:0] res;
    c = CMD_GO_MASK | {7'h00, o[12:8], 12'h472, o[7:0]};
    res = loc == 2'h2 ? BASE_WREG : (loc == 2'h1 ? BASE_DMEM + 32'h10 : BASE_WREG + 32'h10);
    // the unused source gets the inverse so a wrong operand choice shows up
    wr(BASE_WREG + 32'h08, {16'h0000, o[5] ? ~al : al});
    wr(BASE_DMEM + 32'h08, {16'h0000, o[5] ? al : ~al});
    wr(BASE_WREG + 32'h0C, {16'h0000, ah});
    wr(BASE_WREG + 32'h1C, {16'h0000, b});
    wr(BASE_WREG + 32'h10, 32'h0000_5500);
    wr(BASE_WREG + 32'h14, 32'h0000_6600);
    wr(BASE_DMEM + 32'h10, 32'h0000_5500);
    wr(BASE_DMEM + 32'h14, 32'h0000_6600);
    wr(OFF_FLAGS, {27'h0000000, pre});
    wr(OFF_CMD, c);
    rd_chk("result low", res, {16'h0000, e0});
    rd_chk("result high", res + 32'h04, {16'h0000, e1});
    rd_chk("flags", OFF_FLAGS, {27'h0000000, f});
    rd_chk("status", OFF_STAT, 32'h0000_0000);
    rd_chk("command", OFF_CMD, c & ~CMD_GO_MASK);
  endtask : run

  initial begin
    rst_n = 1'b0;
    repeat (3) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd_chk("flags reset", OFF_FLAGS, 32'h0000_0000);
    rd_chk("command reset", OFF_CMD, CMD_RST);
    rd_chk("reg reset", BASE_WREG + 32'h04, 32'h0000_0000);
    wr(32'h0000_0100, 32'hFFFF_FFFF);
    wr(OFF_STAT, 32'h0000_0001);
    rd_chk("unmapped", 32'h0000_0100, 32'h0000_0000);
    rd_chk("status ro", OFF_STAT, 32'h0000_0000);
    run(16'h0000, 16'h7FFF, 16'h0000, 16'h0001, 5'h00, 2'h0, 16'h8000, 16'h6600, 5'h1C);
    run(16'h0001, 16'h0005, 16'h0000, 16'h0005, 5'h00, 2'h0, 16'h0000, 16'h6600, 5'h13);
    run(16'h0001, 16'h0000, 16'h0000, 16'h0001, 5'h00, 2'h0, 16'hFFFF, 16'h6600, 5'h08);
    run(16'h0010, 16'h12FF, 16'h0000, 16'h0001, 5'h00, 2'h0, 16'h5500, 16'h6600, 5'h13);
    run(16'h0002, 16'h8F0F, 16'h0000, 16'hF0F0, 5'h00, 2'h0, 16'h8000, 16'h6600, 5'h08);
    run(16'h0003, 16'h8000, 16'h0000, 16'h0001, 5'h00, 2'h0, 16'h8001, 16'h6600, 5'h08);
    run(16'h0004, 16'h00F0, 16'h0000, 16'h00F0, 5'h15, 2'h0, 16'h0000, 16'h6600, 5'h17);
    run(16'h0060, 16'h0100, 16'h0000, 16'h0023, 5'h00, 2'h1, 16'h0123, 16'h6600, 5'h00);
    run(16'h0025, 16'h8010, 16'h0000, 16'h0004, 5'h15, 2'h0, 16'h0801, 16'h6600, 5'h15);
    run(16'h00A5, 16'h8010, 16'h0000, 16'h0004, 5'h00, 2'h0, 16'hF801, 16'h6600, 5'h08);
    run(16'h0025, 16'h8010, 16'h0000, 16'h003C, 5'h00, 2'h0, 16'h0100, 16'h6600, 5'h00);
    run(16'h0025, 16'h8010, 16'h0000, 16'h0000, 5'h00, 2'h0, 16'h8010, 16'h6600, 5'h08);
    run(16'h0025, 16'h8010, 16'h0000, 16'h0010, 5'h00, 2'h0, 16'h0000, 16'h6600, 5'h02);
    run(16'h00A5, 16'h8010, 16'h0000, 16'h0010, 5'h00, 2'h0, 16'hFFFF, 16'h6600, 5'h08);
    run(16'h0006, 16'hFFFF, 16'h0000, 16'h0002, 5'h15, 2'h0, 16'hFFFE, 16'hFFFF, 5'h15);
    run(16'h0007, 16'hFFFF, 16'h0000, 16'h0002, 5'h00, 2'h0, 16'hFFFE, 16'h0001, 5'h00);
    run(16'h0308, 16'hFFFF, 16'h0000, 16'h0000, 5'h00, 2'h0, 16'hFFFD, 16'hFFFF, 5'h00);
    run(16'h0309, 16'hFFFF, 16'h0000, 16'h0000, 5'h00, 2'h0, 16'hFFFD, 16'h0002, 5'h00);
    run(16'h000A, 16'hFFFF, 16'h0000, 16'hFFFF, 5'h00, 2'h0, 16'h0001, 16'hFFFF, 5'h00);
    run(16'h000B, 16'h12FF, 16'h0000, 16'h34FF, 5'h00, 2'h0, 16'hFE01, 16'h0000, 5'h00);
    run(16'h000C, 16'hFFF9, 16'hFFFF, 16'h0002, 5'h15, 2'h2, 16'hFFFD, 16'hFFFF, 5'h15);
    run(16'h000D, 16'h0005, 16'h0001, 16'h0002, 5'h00, 2'h2, 16'h8002, 16'h0001, 5'h00);
    run(16'h000E, 16'hFFF9, 16'h0001, 16'h0002, 5'h00, 2'h2, 16'hFFFD, 16'hFFFF, 5'h00);
    run(16'h000F, 16'hFFF9, 16'h0001, 16'h0002, 5'h00, 2'h2, 16'h7FFC, 16'h0001, 5'h00);
    tally_and_finish();
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    n_mismatch++;
    tally_and_finish();
  end
endmodule : camds_test
